//--- bench/jtag_ctrl_model.sv
`timescale 1ns/1ns
module jtag_ctrl_model (
  // Pacing clock
  input  wire logic i_clk,
  // Test port pins and cable
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  output logic      o_cable_enable_b,
  // Serial data out as seen on the pin, pulled high while released
  input  wire logic i_tdo
);
  logic        tdo_bit;
  logic [25:0] seen;
  // ------------------------------------------------------------
  // Link driver, 88 ns per bit; the clock stands low between frames
  // ------------------------------------------------------------
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_cable_enable_b = 1'b1;
  end

  // Board ties the select term to this cable signal
  task automatic set_cable(input logic en_b);
    @(negedge i_clk);
    o_cable_enable_b = en_b;
  endtask : set_cable

  task automatic tick(input logic tms, input logic tdi);
    @(negedge i_clk);
    o_tms = tms;
    o_tdi = tdi;
    repeat (5) @(negedge i_clk);
    tdo_bit = i_tdo;
    o_tck = 1'b1;
    repeat (5) @(negedge i_clk);
    o_tck = 1'b0;
  endtask : tick

  task automatic tap_reset;
    repeat (5) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask : tap_reset

  // From idle through one IR or DR scan, LSB first, back to idle
  task automatic scan(input logic ir, input logic [25:0] val, input int n);
    tick(1'b1, 1'b0);
    if (ir) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, val[i]);
      seen[i] = tdo_bit;
    end
    tick(1'b1, ~val[n-1]);
    tick(1'b0, val[n-1]);
  endtask : scan
endmodule : jtag_ctrl_model

//--- bench/test_isp_test_port_control.sv
`timescale 1ns/1ns
module test_isp_test_port_control;
  import isp_test_port_pkg::*;
  logic               i_clk, i_rst_b, dev_reset_b, nvm_ded, nvm_blank, nvm_sec;
  logic [SECTORS-1:0] protect;
  logic               reg_sel, reg_wr, reg_rd;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata, req_data;
  logic               tck, tms, tdi, cable_en_b, tdo, tdo_oe_b, active;
  logic               st_out, st_oe_b, er_out, er_oe_b;
  logic               flash_req, flash_abort, flash_busy, flash_fail;
  flash_op_t          flash_op, req_op;
  logic [1:0]         flash_tgt, req_tgt;
  logic [15:0]        flash_addr, req_addr;
  logic [7:0]         flash_wdata, flash_rdata;
  int                 n_fail, check_count, req_n, n0;

  jtag_ctrl_model model_u (.i_clk(i_clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .o_cable_enable_b(cable_en_b), .i_tdo(tdo_oe_b ? 1'b1 : tdo));

  isp_test_port_control dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_dev_reset_b(dev_reset_b), .i_nvm_port_dedicate(nvm_ded), .i_nvm_blank(nvm_blank),
    .i_nvm_security(nvm_sec), .i_sector_protect(protect), .i_test_select_term(~cable_en_b),
    .i_reg_sel(reg_sel), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe_b(tdo_oe_b), .o_test_port_active(active),
    .o_flash_status_out(st_out), .o_flash_status_oe_b(st_oe_b),
    .o_flash_error_out(er_out), .o_flash_error_oe_b(er_oe_b), .o_flash_req(flash_req),
    .o_flash_op(flash_op), .o_flash_target(flash_tgt), .o_flash_addr(flash_addr),
    .o_flash_wdata(flash_wdata), .o_flash_abort(flash_abort), .i_flash_busy(flash_busy),
    .i_flash_fail(flash_fail), .i_flash_rdata(flash_rdata));

  // ------------------------------------------------------------
  // Clock, request monitor and shared tasks
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // A request stands one cycle, so the falling edge always sees it
  always @(negedge i_clk) begin
    if (flash_req === 1'b1) begin
      req_n++;
      req_op = flash_op;
      req_tgt = flash_tgt;
      req_addr = flash_addr;
      req_data = flash_wdata;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic reg_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    reg_sel = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = ~wr;
    @(negedge i_clk);
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : reg_access

  task automatic isc(input logic [7:0] ir, input logic [25:0] dr);
    model_u.scan(1'b1, {18'h0, ir}, IR_W);
    model_u.scan(1'b0, dr, DR_W);
    repeat (6) @(negedge i_clk);
  endtask : isc

  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #400000;
    n_fail++;
    end_of_test;
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {i_rst_b, nvm_ded, nvm_blank, nvm_sec, reg_sel, reg_wr, reg_rd} = '0;
    {protect, reg_addr, reg_wdata, flash_busy, flash_fail} = '0;
    flash_rdata = 8'ha5;
    dev_reset_b = 1'b1;
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("active_idle", 1'b0, active);
    chk("ext_oe_idle", {1'b1, 1'b1}, {st_oe_b, er_oe_b});
    reg_access(1'b0, TEST_PORT_ENABLE_OFFSET, 8'h00);
    chk("en_reg_reset", TEST_PORT_ENABLE_RESET, reg_rdata);
    reg_access(1'b1, TEST_PORT_ENABLE_OFFSET, 8'h01);
    chk("active_reg", 1'b1, active);
    reg_access(1'b0, TEST_PORT_ENABLE_OFFSET, 8'h00);
    chk("en_reg_read", 8'h01, reg_rdata);
    reg_access(1'b1, 8'hc6, 8'h00);
    reg_access(1'b0, 8'hc6, 8'h00);
    chk("unmapped", {8'h00, 1'b1}, {reg_rdata, active});
    reg_access(1'b1, TEST_PORT_ENABLE_OFFSET, 8'h00);
    chk("active_cleared", 1'b0, active);
    model_u.set_cable(1'b0);
    repeat (4) @(negedge i_clk);
    chk("active_term", 1'b1, active);
    model_u.set_cable(1'b1);
    nvm_blank = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("active_blank", 1'b1, active);
    nvm_blank = 1'b0;
    reg_access(1'b1, TEST_PORT_ENABLE_OFFSET, 8'h01);
    model_u.tap_reset;
    chk("tdo_input", 1'b1, tdo_oe_b);
    isc(ISC_ENABLE, 26'h1);
    chk("tdo_driven", 1'b0, tdo_oe_b);
    chk("ext_on", {1'b0, 1'b1, 1'b0, 1'b1}, {st_oe_b, st_out, er_oe_b, er_out});
    for (int t = 0; t < 4; t++) begin
      n0 = req_n;
      isc(ISC_PROGRAM, {2'(t), 16'h1234 + 16'(t), 8'h5a});
      chk("req_prog", {n0 + 1, 2'(t), OP_PROGRAM}, {req_n, req_tgt, req_op});
    end
    chk("req_addr_data", {16'h1237, 8'h5a}, {req_addr, req_data});
    flash_busy = 1'b1;
    repeat (3) @(negedge i_clk);
    chk("status_busy", 1'b0, st_out);
    flash_fail = 1'b1;
    @(negedge i_clk);
    flash_fail = 1'b0;
    flash_busy = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("error_and_ready", {1'b0, 1'b1}, {er_out, st_out});
    model_u.scan(1'b1, {18'h0, ISC_CLEAR}, IR_W);
    repeat (6) @(negedge i_clk);
    chk("error_clear", {1'b1, IR_CAPTURE}, {er_out, model_u.seen[7:0]});
    isc(ISC_READ, {TGT_PRIMARY, 16'h0040, 8'h00});
    chk("read_data", {8'ha5, OP_READ}, {model_u.seen[7:0], req_op});
    protect = 12'h001;
    n0 = req_n;
    isc(ISC_ERASE, {TGT_PRIMARY, 16'h0000, 8'h00});
    chk("prot_erase", {n0, 1'b0}, {req_n, er_out});
    protect = 12'h000;
    nvm_sec = 1'b1;
    isc(ISC_PROGRAM, {TGT_PRIMARY, 16'h0010, 8'h33});
    chk("secured_prog", n0, req_n);
    isc(ISC_READ, {TGT_PRIMARY, 16'h0040, 8'h00});
    chk("secured_read", {n0, 8'h00}, {req_n, model_u.seen[7:0]});
    isc(ISC_BULK_ERASE, 26'h0);
    chk("bulk_erase", {n0 + 1, OP_BULK_ERASE}, {req_n, req_op});
    nvm_sec = 1'b0;
    isc(ISC_ENABLE, 26'h3);
    chk("od_release", 1'b1, st_oe_b);
    flash_busy = 1'b1;
    repeat (3) @(negedge i_clk);
    chk("od_pull", {1'b0, 1'b0}, {st_oe_b, st_out});
    flash_busy = 1'b0;
    dev_reset_b = 1'b0;
    repeat (6) @(negedge i_clk);
    chk("reset_abort", {1'b1, 1'b0, 1'b1}, {flash_abort, active, tdo_oe_b});
    reg_access(1'b0, TEST_PORT_ENABLE_OFFSET, 8'h00);
    chk("reset_clears_en", 8'h00, reg_rdata);
    dev_reset_b = 1'b1;
    repeat (30) @(negedge i_clk);
    chk("abort_end", {1'b0, 1'b1}, {flash_abort, st_oe_b});
    nvm_ded = 1'b1;
    model_u.tap_reset;
    isc(ISC_ENABLE, 26'h1);
    dev_reset_b = 1'b0;
    repeat (6) @(negedge i_clk);
    chk("dedicated_survives", 4'b1010, {active, tdo_oe_b, st_out, er_out});
    dev_reset_b = 1'b1;
    model_u.scan(1'b1, {18'h0, ISC_DISABLE}, IR_W);
    dev_reset_b = 1'b0;
    repeat (6) @(negedge i_clk);
    dev_reset_b = 1'b1;
    chk("disable_reset", {1'b1, 1'b1}, {tdo_oe_b, er_oe_b});
    isc(ISC_ENABLE, 26'h1);
    chk("err_after_disable", 1'b1, er_out);
    end_of_test;
  end
endmodule : test_isp_test_port_control

//--- core/isp_test_port_control.sv
`timescale 1ns/1ns
module isp_test_port_control
  import isp_test_port_pkg::*;
(
  // Clock and core reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  // Device reset pin, nonvolatile configuration and select term
  input  wire logic                i_dev_reset_b,
  input  wire logic                i_nvm_port_dedicate,
  input  wire logic                i_nvm_blank,
  input  wire logic                i_nvm_security,
  input  wire logic [SECTORS-1:0]  i_sector_protect,
  input  wire logic                i_test_select_term,
  // Processor register port
  input  wire logic                i_reg_sel,
  input  wire logic [7:0]          i_reg_addr,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  input  wire logic [7:0]          i_reg_wdata,
  output logic      [7:0]          o_reg_rdata,
  // Test port pins
  input  wire logic                i_tck,
  input  wire logic                i_tms,
  input  wire logic                i_tdi,
  output logic                     o_tdo,
  output logic                     o_tdo_oe_b,
  output logic                     o_test_port_active,
  // Flash status and error pins
  output logic                     o_flash_status_out,
  output logic                     o_flash_status_oe_b,
  output logic                     o_flash_error_out,
  output logic                     o_flash_error_oe_b,
  // Flash engine
  output logic                     o_flash_req,
  output flash_op_t                o_flash_op,
  output logic      [1:0]          o_flash_target,
  output logic      [15:0]         o_flash_addr,
  output logic      [7:0]          o_flash_wdata,
  output logic                     o_flash_abort,
  input  wire logic                i_flash_busy,
  input  wire logic                i_flash_fail,
  input  wire logic [7:0]          i_flash_rdata
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
    case (s)
      TLR:      tap_next = tms ? TLR      : RTI;
      RTI:      tap_next = tms ? SEL_DR   : RTI;
      SEL_DR:   tap_next = tms ? SEL_IR   : CAP_DR;
      CAP_DR:   tap_next = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: tap_next = tms ? UPD_DR   : PAUSE_DR;
      PAUSE_DR: tap_next = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: tap_next = tms ? UPD_DR   : SHIFT_DR;
      UPD_DR:   tap_next = tms ? SEL_DR   : RTI;
      SEL_IR:   tap_next = tms ? TLR      : CAP_IR;
      CAP_IR:   tap_next = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: tap_next = tms ? UPD_IR   : PAUSE_IR;
      PAUSE_IR: tap_next = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: tap_next = tms ? UPD_IR   : SHIFT_IR;
      UPD_IR:   tap_next = tms ? SEL_DR   : RTI;
      default:  tap_next = TLR;
    endcase
  endfunction : tap_next

  function automatic logic [3:0] sector_of(input logic [1:0] tgt, input logic [15:0] addr);
    if (tgt == TGT_SECONDARY) begin
      sector_of = SECONDARY_FIRST + {2'h0, addr[14:13]};
    end else begin
      sector_of = {1'b0, addr[15:13]};
    end
  endfunction : sector_of

  function automatic logic isc_data_cmd(input logic [7:0] ir);
    isc_data_cmd = (ir == ISC_PROGRAM) || (ir == ISC_ERASE) || (ir == ISC_BULK_ERASE) ||
                   (ir == ISC_READ) || (ir == ISC_VERIFY);
  endfunction : isc_data_cmd

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            tck_s1, tck_s2, tck_p;
    logic            tms_s1, tms_s2, tdi_s1, tdi_s2;
    logic            rst_s1, rst_s2, sel_s1, sel_s2;
    tap_state_t      tap;
    logic [IR_W-1:0] ir, ir_sh;
    logic [DR_W-1:0] dr;
    logic            byp, tdo, isc_en, ext_en, od;
    logic            reg_en, err, dis_seen, sec_clr;
    logic [4:0]      abort_cnt;
    logic            req;
    flash_op_t       op;
    logic [1:0]      tgt;
    logic [15:0]     addr;
    logic [7:0]      wdata, rdata;
    logic            stat_o, stat_oe_b, err_o, err_oe_b;
  } state_t;

  state_t st_r, st_nxt;

  logic dev_rst_active, dedicated, port_on, blocked, running;
  logic tck_rise, tck_fall, secured, dr_sel, stat_val;

  always_comb begin
    dev_rst_active = !st_r.rst_s2;
    dedicated      = i_nvm_port_dedicate || i_nvm_blank;
    port_on        = dedicated || st_r.reg_en || st_r.sel_s2;
    blocked        = dev_rst_active && !dedicated;
    running        = port_on && !blocked;
    tck_rise       = st_r.tck_s2 && !st_r.tck_p;
    tck_fall       = !st_r.tck_s2 && st_r.tck_p;
    secured        = i_nvm_security && !st_r.sec_clr;
    dr_sel         = st_r.isc_en && isc_data_cmd(st_r.ir) || (st_r.ir == ISC_ENABLE);
    stat_val       = !(i_flash_busy || st_r.req);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.req = 1'b0;
    // Pins come from another domain, two stages before anything reads them
    st_nxt.tck_s1 = i_tck;
    st_nxt.tck_s2 = st_r.tck_s1;
    st_nxt.tck_p  = st_r.tck_s2;
    st_nxt.tms_s1 = i_tms;
    st_nxt.tms_s2 = st_r.tms_s1;
    st_nxt.tdi_s1 = i_tdi;
    st_nxt.tdi_s2 = st_r.tdi_s1;
    st_nxt.rst_s1 = i_dev_reset_b;
    st_nxt.rst_s2 = st_r.rst_s1;
    st_nxt.sel_s1 = i_test_select_term;
    st_nxt.sel_s2 = st_r.sel_s1;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    st_nxt.rdata = 8'h00;
    if (i_reg_sel && i_reg_rd && i_reg_addr == TEST_PORT_ENABLE_OFFSET) begin
      st_nxt.rdata[TEST_PORT_ENABLE_BIT] = st_r.reg_en;
    end
    if (i_reg_sel && i_reg_wr && i_reg_addr == TEST_PORT_ENABLE_OFFSET) begin
      st_nxt.reg_en = i_reg_wdata[TEST_PORT_ENABLE_BIT];
    end
    if (dev_rst_active) begin
      st_nxt.reg_en = 1'b0;
    end

    // ----------------------------------------------------------------
    // Test access port
    // ----------------------------------------------------------------
    if (!running) begin
      // A blocked port drops any half-done operation
      st_nxt.tap    = TLR;
      st_nxt.ir     = IR_BYPASS;
      st_nxt.isc_en = 1'b0;
    end else if (tck_rise) begin
      st_nxt.tap = tap_next(st_r.tap, st_r.tms_s2);
      case (st_r.tap)
        TLR: begin
          st_nxt.ir     = IR_BYPASS;
          st_nxt.isc_en = 1'b0;
        end
        CAP_IR:   st_nxt.ir_sh = IR_CAPTURE;
        SHIFT_IR: st_nxt.ir_sh = {st_r.tdi_s2, st_r.ir_sh[IR_W-1:1]};
        UPD_IR: begin
          // Unknown codes, boundary-scan ones included, fall to bypass
          st_nxt.ir = st_r.ir_sh;
          if (st_r.isc_en && st_r.ir_sh == ISC_DISABLE) begin
            st_nxt.isc_en   = 1'b0;
            st_nxt.dis_seen = 1'b1;
          end
          if (st_r.isc_en && st_r.ir_sh == ISC_CLEAR) begin
            st_nxt.err = 1'b0;
          end
        end
        CAP_DR: begin
          st_nxt.byp = 1'b0;
          if (st_r.ir == ISC_READ || st_r.ir == ISC_VERIFY) begin
            st_nxt.dr[DR_DATA_LSB +: 8] = secured ? 8'h00 : i_flash_rdata;
          end
        end
        SHIFT_DR: begin
          st_nxt.byp = st_r.tdi_s2;
          st_nxt.dr  = {st_r.tdi_s2, st_r.dr[DR_W-1:1]};
        end
        UPD_DR: begin
          if (st_r.ir == ISC_ENABLE) begin
            st_nxt.isc_en   = 1'b1;
            st_nxt.ext_en   = st_r.dr[DR_EXT_BIT];
            st_nxt.od       = st_r.dr[DR_OD_BIT];
            st_nxt.dis_seen = 1'b0;
          end else if (st_r.isc_en && isc_data_cmd(st_r.ir) && !i_flash_busy &&
                       !dev_rst_active) begin
            st_nxt.tgt   = st_r.dr[DR_TGT_LSB +: 2];
            st_nxt.addr  = st_r.dr[DR_ADDR_LSB +: 16];
            st_nxt.wdata = st_r.dr[DR_DATA_LSB +: 8];
            case (st_r.ir)
              ISC_PROGRAM:    st_nxt.op = OP_PROGRAM;
              ISC_ERASE:      st_nxt.op = OP_SECTOR_ERASE;
              ISC_BULK_ERASE: st_nxt.op = OP_BULK_ERASE;
              default:        st_nxt.op = OP_READ;
            endcase
            if (st_r.ir == ISC_BULK_ERASE) begin
              st_nxt.req     = 1'b1;
              st_nxt.sec_clr = 1'b1;
            end else if (secured) begin
              st_nxt.req = 1'b0;
            end else if (st_r.ir == ISC_ERASE &&
                         (st_r.dr[DR_TGT_LSB +: 2] == TGT_PRIMARY ||
                          st_r.dr[DR_TGT_LSB +: 2] == TGT_SECONDARY) &&
                         i_sector_protect[sector_of(st_r.dr[DR_TGT_LSB +: 2],
                                                    st_r.dr[DR_ADDR_LSB +: 16])]) begin
              st_nxt.err = 1'b1;
            end else begin
              st_nxt.req = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end else if (tck_fall) begin
      if (st_r.tap == SHIFT_IR) begin
        st_nxt.tdo = st_r.ir_sh[0];
      end else if (st_r.tap == SHIFT_DR) begin
        st_nxt.tdo = dr_sel ? st_r.dr[0] : st_r.byp;
      end
    end

    // ----------------------------------------------------------------
    // Error flag, flash abort and extension pins
    // ----------------------------------------------------------------
    if (dev_rst_active && st_r.dis_seen) begin
      st_nxt.err      = 1'b0;
      st_nxt.ext_en   = 1'b0;
      st_nxt.dis_seen = 1'b0;
    end
    if (i_flash_fail && (st_r.op == OP_PROGRAM || st_r.op == OP_SECTOR_ERASE)) begin
      st_nxt.err = 1'b1;
    end

    // Abort is stretched so a short reset still ends the flash cycle
    if (dev_rst_active) begin
      st_nxt.abort_cnt = RESET_ABORT_CYC;
    end else if (st_r.abort_cnt != 5'h00) begin
      st_nxt.abort_cnt = st_r.abort_cnt - 5'h01;
    end

    st_nxt.stat_oe_b = 1'b1;
    st_nxt.err_oe_b  = 1'b1;
    st_nxt.stat_o    = 1'b0;
    st_nxt.err_o     = 1'b0;
    if (running && st_r.ext_en) begin
      if (st_r.od) begin
        st_nxt.stat_oe_b = stat_val;
        st_nxt.err_oe_b  = !st_r.err;
      end else begin
        st_nxt.stat_o    = stat_val;
        st_nxt.err_o     = !st_r.err;
        st_nxt.stat_oe_b = 1'b0;
        st_nxt.err_oe_b  = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r           <= '0;
      st_r.tap       <= TLR;
      st_r.ir        <= IR_BYPASS;
      st_r.op        <= OP_NONE;
      st_r.reg_en    <= TEST_PORT_ENABLE_RESET[TEST_PORT_ENABLE_BIT];
      st_r.stat_oe_b <= 1'b1;
      st_r.err_oe_b  <= 1'b1;
      // Device reset pin idles high; a zero here would fake a reset after core reset
      st_r.rst_s1    <= 1'b1;
      st_r.rst_s2    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata         = st_r.rdata;
  assign o_test_port_active  = port_on;
  assign o_tdo               = st_r.tdo;
  assign o_tdo_oe_b          = !(running && st_r.isc_en);
  assign o_flash_status_out  = st_r.stat_o;
  assign o_flash_status_oe_b = st_r.stat_oe_b;
  assign o_flash_error_out   = st_r.err_o;
  assign o_flash_error_oe_b  = st_r.err_oe_b;
  assign o_flash_req         = st_r.req;
  assign o_flash_op          = st_r.op;
  assign o_flash_target      = st_r.tgt;
  assign o_flash_addr        = st_r.addr;
  assign o_flash_wdata       = st_r.wdata;
  assign o_flash_abort       = dev_rst_active || (st_r.abort_cnt != 5'h00);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_port_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !port_on |-> o_tdo_oe_b && !o_test_port_active)
    else $error("test pins not released");

  chk_tdo_before_enable: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !st_r.isc_en |-> o_tdo_oe_b)
    else $error("serial out driven before enable");

  chk_reg_reset_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    dev_rst_active |=> !st_r.reg_en ##1 (o_reg_rdata == 8'h00))
    else $error("enable bit survived device reset");

  chk_reg_write_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_reg_sel && i_reg_wr && i_reg_addr == TEST_PORT_ENABLE_OFFSET && i_reg_wdata[0] &&
    !dev_rst_active |=> o_test_port_active)
    else $error("register write did not enable port");

  chk_reset_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    blocked |=> st_r.tap == TLR && !st_r.isc_en)
    else $error("register-enabled port ran during reset");

  chk_dedicated_holds: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    dedicated && dev_rst_active && st_r.isc_en && !tck_rise |=> st_r.isc_en)
    else $error("dedicated port disturbed by reset");

  chk_secure_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    secured |=> !(o_flash_req && o_flash_op != OP_BULK_ERASE))
    else $error("secured device issued command");

  chk_protect_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_flash_req && o_flash_op == OP_SECTOR_ERASE && o_flash_target != TGT_LOGIC &&
    o_flash_target != TGT_CONFIG |-> !i_sector_protect[sector_of(o_flash_target, o_flash_addr)])
    else $error("protected sector erased");

  chk_error_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_flash_fail && o_flash_op == OP_PROGRAM |=> st_r.err)
    else $error("flash failure not flagged");

  chk_abort_stretch: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    dev_rst_active |=> o_flash_abort [*8])
    else $error("flash abort too short");

endmodule : isp_test_port_control

//--- core/isp_test_port_pkg.sv
// Functional notes
// - Test pins dedicated when NVM bit, run-time bit or select term is true.
// - Enabled pins stay inputs; serial data out drives only after enable command.
// - With no enable source true, the four pins return to general I/O.
// - Run-time enable register at C7h from I/O block base; writing one enables.
// - Any device reset clears the run-time enable bit; writing zero clears it.
// - A blank device has the four test pins enabled by default.
// - NVM-dedicated port keeps running through an active device reset.
// - Register-only enabled port is aborted and blocked by device reset.
// - Configuration instruction set supported; boundary-scan codes act as bypass.
// - Status and error outputs stay disabled until the enable command.
// - Error output low on failed erase/program until clear, or reset after disable.
// - Status high in read mode, low while program or erase runs.
// - Enable command option makes status and error outputs open-drain.
// - Secured device refuses every command except full chip erase.
// - Full chip erase clears security, leaving device blank and unsecured.
// - One protect bit per sector; erasing a protected sector is refused.
// - Device reset aborts flash cycles, returning to read mode in time.
// - Port reaches primary, secondary flash, logic and configuration bits.
// - Enable register bit 0 enables the port; upper bits unused, read zero.
package isp_test_port_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TEST_PORT_ENABLE_OFFSET = 8'hc7;
  localparam int         TEST_PORT_ENABLE_BIT    = 0;
  localparam logic [7:0] TEST_PORT_ENABLE_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Instruction register and data register layout
  // ----------------------------------------------------------------
  localparam int         IR_W           = 8;
  localparam logic [7:0] IR_CAPTURE     = 8'h01;
  localparam logic [7:0] ISC_ENABLE     = 8'h10;
  localparam logic [7:0] ISC_DISABLE    = 8'h11;
  localparam logic [7:0] ISC_CLEAR      = 8'h12;
  localparam logic [7:0] ISC_PROGRAM    = 8'h13;
  localparam logic [7:0] ISC_ERASE      = 8'h14;
  localparam logic [7:0] ISC_BULK_ERASE = 8'h15;
  localparam logic [7:0] ISC_READ       = 8'h16;
  localparam logic [7:0] ISC_VERIFY     = 8'h17;
  localparam logic [7:0] IR_BYPASS      = 8'hff;

  localparam int DR_W        = 26;
  localparam int DR_DATA_LSB = 0;
  localparam int DR_ADDR_LSB = 8;
  localparam int DR_TGT_LSB  = 24;
  localparam int DR_EXT_BIT  = 0;
  localparam int DR_OD_BIT   = 1;

  localparam logic [1:0] TGT_PRIMARY   = 2'h0;
  localparam logic [1:0] TGT_SECONDARY = 2'h1;
  localparam logic [1:0] TGT_LOGIC     = 2'h2;
  localparam logic [1:0] TGT_CONFIG    = 2'h3;

  localparam int         SECTORS         = 12;
  localparam logic [3:0] SECONDARY_FIRST = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS   = 8;
  localparam int         RESET_ABORT_NS  = 200;
  localparam logic [4:0] RESET_ABORT_CYC = 5'(RESET_ABORT_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_BULK_ERASE
  } flash_op_t;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;

endpackage : isp_test_port_pkg
